// >>> pkg/gpd_pkg.sv
package gpd_pkg;

  localparam int NUM_PORTS = 4;
  localparam int PIN_W = 16;

  // implemented pins per port, index 0 is the first port
  localparam logic [3:0][15:0] PORT_PIN_MASK = {16'h000f, 16'hffff, 16'h00ff, 16'hffff};

  // absolute base of the first port; hsel decodes the upper address bits outside
  localparam logic [31:0] GPIO_BASE = 32'h4000_2000;
  localparam int PORT_SEL_LSB = 8;

  // register offsets inside one port's 0x100 window; the unlock key sits at 0xff0, outside the port windows
  localparam logic [7:0] OFS_OUTPUT_LEVEL = 8'h00;
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h04;
  localparam logic [7:0] OFS_BIT_SET = 8'h08;
  localparam logic [7:0] OFS_BIT_CLEAR = 8'h0c;
  localparam logic [7:0] OFS_PIN_MODE = 8'h10;
  localparam logic [7:0] OFS_DEBOUNCE_EN = 8'h14;
  localparam logic [7:0] OFS_DEBOUNCE_CLK = 8'h18;
  localparam logic [7:0] OFS_PIN_MUX = 8'h1c;
  localparam logic [11:0] OFS_UNLOCK_KEY = 12'hff0;

  localparam logic [15:0] OUTPUT_LEVEL_RST = 16'h0000;
  localparam logic [15:0] PIN_LEVEL_RST = 16'h0000;
  localparam logic [31:0] PIN_MODE_RST = 32'haaaa_aaaa;
  localparam logic [15:0] DEBOUNCE_EN_RST = 16'h0000;
  localparam logic [15:0] PIN_MUX_RST = 16'h0000;
  localparam int DEBOUNCE_CLOCK_SELECT_SEL_W = 3;
  localparam logic [2:0] DEBOUNCE_CLK_RST = 3'h0;
  localparam int PRESCALE_W = 8;

  localparam logic [7:0] KEY_FIRST = 8'h15;
  localparam logic [7:0] KEY_SECOND = 8'h51;

  localparam logic [1:0] MODE_PUSH_PULL = 2'b00;
  localparam logic [1:0] MODE_OPEN_DRAIN = 2'b01;
  localparam logic [1:0] MODE_INPUT = 2'b10;
  localparam logic [1:0] MODE_ANALOG = 2'b11;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;

  typedef enum {LOCK_CLOSED, LOCK_HALF, LOCK_OPEN} gpd_lock_e;

  typedef struct packed {
    logic [15:0] level;
    logic [15:0] enable;
  } gpd_pad_s;

endpackage

// >>> logic/gpd_debounce.sv
`timescale 1ns/100ps
module gpd_debounce #(
  parameter int WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sampleTick,
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] filtered
);
  import gpd_pkg::*;

  genvar j;
  generate
    for (j = 0; j < WIDTH; j++)
    begin : g_pin
      logic [1:0] historyQ;
      logic filtQ;

      // history only moves on the group tick, so the filter sees the slow sample clock
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
          historyQ <= 2'b00;
        else if (sampleTick)
          historyQ <= {historyQ[0], rawIn[j]};
      end

      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
          filtQ <= 1'b0;
        else if (historyQ == 2'b01)
          filtQ <= 1'b1;
        else if (historyQ == 2'b10)
          filtQ <= 1'b0;
      end

      assign filtered[j] = filtQ;
    end
  endgenerate
endmodule

// >>> logic/gpd_gpio_port.sv
`timescale 1ns/100ps
// Behaviour
// - any other key write relocks the configuration registers.
// - a read between the two key writes aborts unlocking.
// - pins stay disabled after reset until enabled, except always-on pins.
// - input mode turns the pin's output driver off in GPIO function.
// - pin mux picks the driven function; GPIO path only in GPIO function.
// - pin level register samples raw or debounced value every clock.
// - with debounce on, input is sampled on the debounce clock.
// - each port group has its own selectable debounce clock.
// - GPIO output drives low for bit 0, high for bit 1 in push-pull; open drain releases the pin for bit 1.
// - pin level reads each enabled pin's level, except in analog mode.
// - bit set write forces ones where written bits are one.
// - bit clear write forces zeros where written bits are one.
// - four ports at 0x100 spacing, output, input, set, clear at successive words.
// - every pin has its own debounce filter with per-pin enable.
module gpd_gpio_port #(
  parameter logic [3:0][15:0] ALWAYS_ON = 64'h0000_0000_0000_0000
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] portEnable,
  input wire logic [3:0][15:0] padIn,
  input gpd_pkg::gpd_pad_s [3:0] altDrive,
  output gpd_pkg::gpd_pad_s [3:0] padDrive
);
  import gpd_pkg::*;

  logic addrAccept;
  logic pendWrQ;
  logic pendRdQ;
  logic [11:0] addrQ;
  logic readyQ;
  logic [31:0] rdataQ;
  logic [31:0] rdNext;
  logic inPortSpace;
  logic keyWr;
  logic lockOpen;
  gpd_lock_e lockQ;
  gpd_lock_e lockAfterWr;
  logic [PRESCALE_W-1:0] prescaleQ;

  logic [15:0] outLevelQ [NUM_PORTS];
  logic [15:0] pinLevelQ [NUM_PORTS];
  logic [31:0] pinModeQ [NUM_PORTS];
  logic [15:0] dbEnQ [NUM_PORTS];
  logic [15:0] pinMuxQ [NUM_PORTS];
  logic [DEBOUNCE_CLOCK_SELECT_SEL_W-1:0] dbSelQ [NUM_PORTS];
  gpd_pad_s [3:0] padQ;

  assign addrAccept = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign inPortSpace = (addrQ[11:10] == 2'b00);
  assign keyWr = pendWrQ && (addrQ == OFS_UNLOCK_KEY);
  assign lockOpen = (lockQ == LOCK_OPEN);

  // address phase capture; non-word writes are dropped since only full words are mapped
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pendWrQ <= 1'b0;
      pendRdQ <= 1'b0;
      addrQ <= 12'h000;
    end
    else
    begin
      pendWrQ <= addrAccept && hwrite && (hsize == HSIZE_WORD);
      pendRdQ <= addrAccept && !hwrite;
      if (addrAccept)
        addrQ <= haddr[11:0];
    end
  end

  // reads take one wait state so that a write just before is already visible
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      readyQ <= 1'b1;
      rdataQ <= 32'h0000_0000;
    end
    else if (pendRdQ && !readyQ)
    begin
      readyQ <= 1'b1;
      rdataQ <= rdNext;
    end
    else if (addrAccept && !hwrite)
      readyQ <= 1'b0;
  end

  assign hreadyout = readyQ;
  assign hrdata = rdataQ;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  always_comb
  begin
    rdNext = 32'h0000_0000;
    if (inPortSpace)
    begin
      case (addrQ[7:0])
        OFS_OUTPUT_LEVEL: rdNext = {16'h0000, outLevelQ[addrQ[9:8]]};
        OFS_PIN_LEVEL: rdNext = {16'h0000, pinLevelQ[addrQ[9:8]]};
        OFS_PIN_MODE: rdNext = pinModeQ[addrQ[9:8]];
        OFS_DEBOUNCE_EN: rdNext = {16'h0000, dbEnQ[addrQ[9:8]]};
        OFS_DEBOUNCE_CLK: rdNext = {29'h0000_0000, dbSelQ[addrQ[9:8]]};
        OFS_PIN_MUX: rdNext = {16'h0000, pinMuxQ[addrQ[9:8]]};
        default: rdNext = 32'h0000_0000;
      endcase
    end
  end

  always_comb
  begin
    lockAfterWr = lockQ;
    if (keyWr)
    begin
      if (hwdata[31:0] == {24'h00_0000, KEY_FIRST})
        lockAfterWr = LOCK_HALF;
      else if ((lockQ == LOCK_HALF) && (hwdata[31:0] == {24'h00_0000, KEY_SECOND}))
        lockAfterWr = LOCK_OPEN;
      else
        lockAfterWr = LOCK_CLOSED;
    end
  end

  // a read taken beside the first key write wins over it; one beside the second key write still lets the lock open
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      lockQ <= LOCK_CLOSED;
    else
    begin
      case (lockAfterWr)
        LOCK_HALF: lockQ <= (addrAccept && !hwrite) ? LOCK_CLOSED : LOCK_HALF;
        LOCK_OPEN: lockQ <= LOCK_OPEN;
        LOCK_CLOSED: lockQ <= LOCK_CLOSED;
        default: lockQ <= LOCK_CLOSED;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      prescaleQ <= '0;
    else
      prescaleQ <= prescaleQ + 1'b1;
  end

  genvar p;
  genvar j;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      logic wrThis;
      logic cfgWr;
      logic [15:0] mask;
      logic [15:0] wrBits;
      logic [PRESCALE_W-1:0] tickMask;
      logic tick;
      logic [15:0] filtered;
      logic [15:0] levelNext;
      gpd_pad_s padNext;

      assign mask = PORT_PIN_MASK[p];
      assign wrBits = hwdata[15:0] & mask;
      assign wrThis = pendWrQ && inPortSpace && (addrQ[9:8] == 2'(p));
      assign cfgWr = wrThis && lockOpen;

      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
          outLevelQ[p] <= OUTPUT_LEVEL_RST;
        else if (wrThis)
        begin
          case (addrQ[7:0])
            OFS_OUTPUT_LEVEL: outLevelQ[p] <= wrBits;
            OFS_BIT_SET: outLevelQ[p] <= outLevelQ[p] | wrBits;
            OFS_BIT_CLEAR: outLevelQ[p] <= outLevelQ[p] & ~wrBits;
            default: outLevelQ[p] <= outLevelQ[p];
          endcase
        end
      end

      // configuration only moves while the unlock key is open
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          pinModeQ[p] <= PIN_MODE_RST;
          dbEnQ[p] <= DEBOUNCE_EN_RST;
          pinMuxQ[p] <= PIN_MUX_RST;
          dbSelQ[p] <= DEBOUNCE_CLK_RST;
        end
        else if (cfgWr)
        begin
          case (addrQ[7:0])
            OFS_PIN_MODE: pinModeQ[p] <= hwdata;
            OFS_DEBOUNCE_EN: dbEnQ[p] <= wrBits;
            OFS_PIN_MUX: pinMuxQ[p] <= wrBits;
            OFS_DEBOUNCE_CLK: dbSelQ[p] <= hwdata[DEBOUNCE_CLOCK_SELECT_SEL_W-1:0];
            default: dbSelQ[p] <= dbSelQ[p];
          endcase
        end
      end

      // select n ticks once every 2^(n+1) cycles
      assign tickMask = PRESCALE_W'((16'h0002 << dbSelQ[p]) - 16'h0001);
      assign tick = &(prescaleQ | ~tickMask);

      gpd_debounce #(
        .WIDTH(PIN_W)
      ) u_debounce (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .sampleTick(tick),
        .rawIn(padIn[p]),
        .filtered(filtered)
      );

      for (j = 0; j < PIN_W; j++)
      begin : g_bit
        logic pinOn;
        logic [1:0] mode;
        logic sampled;

        assign pinOn = (portEnable[p] || ALWAYS_ON[p][j]) && mask[j];
        assign mode = pinModeQ[p][2*j+1:2*j];
        assign sampled = dbEnQ[p][j] ? filtered[j] : padIn[p][j];
        assign levelNext[j] = pinOn && (mode != MODE_ANALOG) && sampled;

        always_comb
        begin
          padNext.level[j] = 1'b0;
          padNext.enable[j] = 1'b0;
          if (!pinOn)
            padNext.enable[j] = 1'b0;
          else if (pinMuxQ[p][j])
          begin
            padNext.level[j] = altDrive[p].level[j];
            padNext.enable[j] = altDrive[p].enable[j];
          end
          else
          begin
            case (mode)
              MODE_PUSH_PULL:
              begin
                padNext.level[j] = outLevelQ[p][j];
                padNext.enable[j] = 1'b1;
              end
              MODE_OPEN_DRAIN:
              begin
                padNext.level[j] = 1'b0;
                padNext.enable[j] = !outLevelQ[p][j];
              end
              MODE_INPUT: padNext.enable[j] = 1'b0;
              default: padNext.enable[j] = 1'b0;
            endcase
          end
        end
      end

      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
          pinLevelQ[p] <= PIN_LEVEL_RST;
        else
          pinLevelQ[p] <= levelNext;
      end

      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
          padQ[p] <= '0;
        else
          padQ[p] <= padNext;
      end
    end
  endgenerate

  assign padDrive = padQ;
endmodule

// >>> testbench/gpd_pads.sv
`timescale 1ns/100ps
module gpd_pads (
  input wire gpd_pkg::gpd_pad_s [3:0] padDrive,
  input wire logic [3:0][15:0] extLevel,
  output logic [3:0][15:0] padIn
);
  import gpd_pkg::*;
  // a driven pin shows its own level, a released one follows the outside world
  always_comb
    for (int p = 0; p < NUM_PORTS; p++)
      padIn[p] = (padDrive[p].level & padDrive[p].enable) | (extLevel[p] & ~padDrive[p].enable);
endmodule

// >>> testbench/gpd_gpio_port_props.sv
`timescale 1ns/100ps
module gpd_gpio_port_props #(
  parameter logic [3:0][15:0] ALWAYS_ON = 64'h0
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [3:0] portEnable,
  input wire logic [3:0][15:0] padIn,
  input wire gpd_pkg::gpd_pad_s [3:0] altDrive,
  input wire gpd_pkg::gpd_pad_s [3:0] padDrive
);
  import gpd_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence taken;
    hsel && hready && htrans == HTRANS_NONSEQ;
  endsequence
  sequence rdTaken;
    taken ##0 !hwrite;
  endsequence
  a_resp_okay: assert property (hresp == 1'h0) else $error("hresp not okay");
  a_write_no_wait: assert property (taken ##0 hwrite |=> hreadyout) else $error("write stalled");
  a_read_one_wait: assert property (rdTaken |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(!hreadyout)) else $error("hrdata moved");
  a_narrow_portb: assert property (rdTaken ##0 haddr[11:4] == 8'h10 |-> ##2 hrdata[31:8] == 24'h0)
    else $error("port b upper bits");
  a_narrow_portd: assert property (rdTaken ##0 haddr[11:4] == 8'h30 |-> ##2 hrdata[31:4] == 28'h0)
    else $error("port d upper bits");
  a_wo_read_zero: assert property (rdTaken ##0 haddr[7:3] == 5'h01 && !haddr[11] |-> ##2 hrdata == 32'h0)
    else $error("set or clear read not zero");
  a_key_read_zero: assert property (rdTaken ##0 haddr[11:0] == OFS_UNLOCK_KEY |-> ##2 hrdata == 32'h0)
    else $error("key read not zero");
  a_pad_disabled: assert property (!portEnable[0] [*2] |-> (padDrive[0].enable & ~ALWAYS_ON[0]) == 16'h0)
    else $error("disabled port drives");
endmodule
bind gpd_gpio_port gpd_gpio_port_props #(.ALWAYS_ON(ALWAYS_ON)) u_props (.core_clk(core_clk), .rst_b(rst_b),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .portEnable(portEnable), .padIn(padIn),
  .altDrive(altDrive), .padDrive(padDrive));

// >>> testbench/gpd_gpio_port_tb.sv
`timescale 1ns/100ps
module gpd_gpio_port_tb;
  import gpd_pkg::*;
  logic core_clk = 1'h0;
  logic rst_b = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [3:0] portEnable = 4'h0;
  logic [3:0][15:0] padIn;
  logic [3:0][15:0] extLevel = 64'h0;
  gpd_pad_s [3:0] altDrive = 128'h0;
  gpd_pad_s [3:0] padDrive;
  int failures = 0;
  int checked = 0;
  int seed = 32'h85df0560;
  logic [31:0] v, s, c, got, exp0;
  always #4 core_clk = ~core_clk;
  gpd_gpio_port u_dut (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .portEnable(portEnable), .padIn(padIn), .altDrive(altDrive),
    .padDrive(padDrive));
  gpd_pads u_pads (.padDrive(padDrive), .extLevel(extLevel), .padIn(padIn));
  function automatic logic [31:0] drv(input int p, input logic [31:0] x);
    return {16'h0, x[15:0] & PORT_PIN_MASK[p]};
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= GPIO_BASE | {20'h0, a};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    got = hrdata;
  endtask
  task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'h0, a, 32'h0);
    chk(name, exp, got);
  endtask
  task automatic test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    test_done;
  end
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'h1;
    portEnable <= 4'hf;
    @(posedge core_clk);
    rdchk("out level", 12'h000, 32'h0);
    rdchk("pin mode", 12'h010, PIN_MODE_RST);
    chk("input drive", 32'h0, {16'h0, padDrive[0].enable});
    // locked write, then a read that breaks the key pair
    xfer(1'h1, 12'h010, 32'h0);
    xfer(1'h1, OFS_UNLOCK_KEY, 32'h15);
    rdchk("unmapped", 12'h020, 32'h0);
    xfer(1'h1, OFS_UNLOCK_KEY, 32'h51);
    xfer(1'h1, 12'h010, 32'h0);
    rdchk("mode locked", 12'h010, PIN_MODE_RST);
    xfer(1'h1, OFS_UNLOCK_KEY, 32'h15);
    xfer(1'h1, OFS_UNLOCK_KEY, 32'h51);
    xfer(1'h1, 12'h010, 32'h0);
    xfer(1'h1, 12'h214, 32'h1);
    xfer(1'h1, 12'h218, 32'hff);
    xfer(1'h1, 12'h11c, 32'h1);
    rdchk("mode open", 12'h010, 32'h0);
    rdchk("debounce clock", 12'h218, 32'h7);
    xfer(1'h1, OFS_UNLOCK_KEY, 32'h0);
    xfer(1'h1, 12'h010, 32'h5555_5555);
    rdchk("mode relocked", 12'h010, 32'h0);
    rdchk("key read", OFS_UNLOCK_KEY, 32'h0);
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      v = $random(seed);
      s = $random(seed);
      c = (p == 3) ? 32'hffff : $random(seed);
      xfer(1'h1, 12'(p * 256), v);
      xfer(1'h1, 12'(p * 256 + 8), s);
      xfer(1'h1, 12'(p * 256 + 12), c);
      rdchk("out level", 12'(p * 256), drv(p, (v | s) & ~c));
      rdchk("set read", 12'(p * 256 + 8), 32'h0);
      // the loop reuses v, s and c, so keep the first port's level for the pad check
      if (p == 0)
        exp0 = drv(0, (v | s) & ~c);
    end
    chk("pad level", exp0, {16'h0, padDrive[0].level});
    chk("pad enable", 32'hffff, {16'h0, padDrive[0].enable});
    portEnable <= 4'he;
    altDrive <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    extLevel <= {$random(seed), $random(seed)};
    repeat (3) @(posedge core_clk);
    chk("disabled", 32'h0, {16'h0, padDrive[0].enable});
    chk("alt drive", {30'h0, altDrive[1].level[0], altDrive[1].enable[0]},
      {30'h0, padDrive[1].level[0], padDrive[1].enable[0]});
    rdchk("pin level", 12'h304, drv(3, extLevel[3]));
    // the slowest debounce clock needs several ticks to settle
    repeat (800) @(posedge core_clk);
    rdchk("debounced", 12'h204, drv(2, extLevel[2]));
    test_done;
  end
endmodule
